// ### dbt_pkg.sv
// Shared constants for the divider balance tracker
package dbt_pkg;

   // ==========================================================
   // Wiper geometry
   localparam int          POS_W      = 6;
   localparam logic [5:0]  POS_MAX    = 6'h3f;
   localparam logic [5:0]  POS_MIN    = 6'h00;
   localparam logic [5:0]  CAL_STEPS  = 6'h3f;   // Burst to reach the top
   localparam logic [6:0]  INC_LIMIT  = 7'h3f;   // Increments without edge

   // ==========================================================
   // Timing
   localparam int CLK_MHZ       = 25;
   localparam int DIR_SETUP_NS  = 1500000;       // Direction hold before fall
   localparam int STEP_HALF_NS  = 2000;          // Half period of one step
   localparam int DIR_SETUP_CYC = (DIR_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP_HALF_CYC = (STEP_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int TMR_W         = 20;

   // ==========================================================
   // Host serial read port
   localparam logic [6:0] I2C_ADDR_DEF = 7'h2a;  // Arbitrary bus address
   localparam logic [3:0] I2C_BITS     = 4'h8;
   localparam logic [1:0] POS_PAD      = 2'h0;

   // ==========================================================
   // Edge detector bit positions
   localparam int EV_CMP = 0;
   localparam int EV_TRK = 1;
   localparam int EV_CAL = 2;
   localparam int EV_W   = 3;

endpackage

// ### dbt_step_if.sv
// Carrier between the balance controller and the step pulse driver
`timescale 1ns/1ps
interface dbt_step_if;
   logic run;    // Keep stepping while high
   logic up;     // Direction of the burst, sampled at start
   logic step;   // One-cycle pulse per rising edge issued
   logic busy;   // Select is low or a burst is being set up

   modport ctrl (output run, output up, input step, input busy);
   modport drv  (input run, input up, output step, output busy);
endinterface

// ### dbt_edge_det.sv
// Rising edge and change detector for a small group of levels
`timescale 1ns/1ps
module dbt_edge_det #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] rise_o,
   output logic      [W-1:0] chg_o
);
   logic [W-1:0] prev_q;
   logic         prime_q;

   // ==========================================================
   // History; no edge is reported before the first sample
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         prev_q  <= '0;
         prime_q <= 1'b0;
      end
      else
      begin
         prev_q  <= d_i;
         prime_q <= 1'b1;
      end
   end

   // Suppressing the first cycle stops a level held through reset
   // from looking like a fresh request
   assign rise_o = prime_q ? (d_i & ~prev_q) : '0;
   assign chg_o  = prime_q ? (d_i ^ prev_q) : '0;
endmodule

// ### dbt_stepper.sv
// Drives the select and direction/step pins of the potentiometer
`timescale 1ns/1ps
module dbt_stepper
   import dbt_pkg::*;
#(
   parameter int SETUP_CYC = DIR_SETUP_CYC,
   parameter int HALF_CYC  = STEP_HALF_CYC
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   dbt_step_if.drv   st,
   output logic      wiper_select_n_o,
   output logic      dir_step_o
);
   typedef enum logic [1:0] {S_IDLE, S_SETUP, S_SEL, S_PH0} dbt_sst_t;

   localparam logic [TMR_W-1:0] SETUP_LD = TMR_W'(SETUP_CYC - 1);
   localparam logic [TMR_W-1:0] HALF_LD  = TMR_W'(HALF_CYC - 1);

   dbt_sst_t         st_q;
   logic [TMR_W-1:0] tmr_q;
   logic             dir_q;
   logic             step_q;
   logic             tmr_done;

   assign tmr_done = (tmr_q == '0);
   assign st.step  = step_q;
   assign st.busy  = (st_q != S_IDLE);

   // ==========================================================
   // Step sequence; S_SEL doubles as the second half of a step
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         st_q             <= S_IDLE;
         tmr_q            <= '0;
         dir_q            <= 1'b0;
         step_q           <= 1'b0;
         wiper_select_n_o <= 1'b1;
         dir_step_o       <= 1'b0;
      end
      else
      begin
         step_q <= 1'b0;
         if (!tmr_done)
            tmr_q <= tmr_q - 1'b1;
         unique case (st_q)
            S_IDLE:
            begin
               wiper_select_n_o <= 1'b1;
               if (st.run)
               begin
                  dir_q      <= st.up;
                  dir_step_o <= st.up;
                  tmr_q      <= SETUP_LD;
                  st_q       <= S_SETUP;
               end
            end
            S_SETUP:
               if (tmr_done)
               begin
                  // Direction has been steady long enough to be latched
                  wiper_select_n_o <= 1'b0;
                  tmr_q            <= HALF_LD;
                  st_q             <= S_SEL;
               end
            S_SEL:
               if (tmr_done)
               begin
                  if (!st.run)
                  begin
                     wiper_select_n_o <= 1'b1;
                     st_q             <= S_IDLE;
                  end
                  else
                  begin
                     // Decrement rises here, increment falls
                     dir_step_o <= ~dir_q;
                     step_q     <= ~dir_q;
                     tmr_q      <= HALF_LD;
                     st_q       <= S_PH0;
                  end
               end
            S_PH0:
               if (tmr_done)
               begin
                  dir_step_o <= dir_q;
                  step_q     <= dir_q;
                  tmr_q      <= HALF_LD;
                  st_q       <= S_SEL;
               end
         endcase
      end
   end
endmodule

// ### dbt_tracker.sv
// Digital potentiometer balance tracker with serial position readout
// What this block does
// - Track a 64-position wiper as six bits
// - Position counter readable over I2C anytime
// - Either enable rising starts stepping toward threshold
// - Calibration drives to maximum, then decrements
// - Count moves one per issued step short of either end, where it holds
// - Tracking steps from the running count
// - Select low while stepping, high otherwise
// - Direction level at select fall sets direction
// - One rising edge per counted step
// - Flag out-of-bounds at either resistance limit
// - Calibration wins over tracking
// - Calibration bursts 63 increments, presets maximum
// - Stop stepping on a comparator edge, except during the calibration burst
// - Flag below zero or a 64th unbroken increment
`timescale 1ns/1ps
module dbt_tracker
   import dbt_pkg::*;
#(
   parameter int         SETUP_CYC = DIR_SETUP_CYC,
   parameter int         HALF_CYC  = STEP_HALF_CYC,
   parameter logic [6:0] I2C_ADDR  = I2C_ADDR_DEF
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic cal_en_i,
   input  wire logic track_en_i,
   input  wire logic cmp_above_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o,
   output logic      wiper_select_n_o,
   output logic      dir_step_o,
   output logic      limit_reached_flag_o
);
   typedef enum logic [2:0] {
      C_IDLE, C_CAL_UP, C_CAL_WAIT, C_CAL_DN, C_TRACK, C_DRAIN
   } dbt_cst_t;

   typedef enum logic [2:0] {
      I_IDLE, I_ADDR, I_AACK, I_TX, I_RACK, I_RX, I_WACK
   } dbt_ist_t;

   // ==========================================================
   // Saturating one-step move of the wiper position
   function automatic logic [POS_W-1:0] sat_step(
      input logic [POS_W-1:0] p,
      input logic             inc
   );
      logic [POS_W-1:0] r;
      r = p;
      if (inc && p != POS_MAX)
         r = p + 1'b1;
      else if (!inc && p != POS_MIN)
         r = p - 1'b1;
      return r;
   endfunction

   dbt_step_if stp ();

   dbt_cst_t         cst_q;
   logic             run_q;
   logic             up_q;
   logic [POS_W-1:0] pos_q;
   logic [5:0]       burst_q;
   logic [6:0]       inc_run_q;
   logic             oob_set;
   logic             start;
   logic             cal_start;
   logic             stepping;
   logic [EV_W-1:0]  ev_rise;
   logic [EV_W-1:0]  ev_chg;
   logic             cmp_edge;

   // ==========================================================
   // Edge detection of comparator and enables
   dbt_edge_det #(
      .W (EV_W)
   ) u_edge (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    ({cal_en_i, track_en_i, cmp_above_i}),
      .rise_o (ev_rise),
      .chg_o  (ev_chg)
   );

   assign cmp_edge  = ev_chg[EV_CMP];
   // Calibration outranks tracking even when tracking rises alone
   assign cal_start = (cst_q == C_IDLE) && ev_rise[EV_CAL];
   assign start     = (cst_q == C_IDLE) && (ev_rise[EV_CAL] ||
                      (ev_rise[EV_TRK] && !cal_en_i));
   assign stepping  = (cst_q == C_CAL_DN) || (cst_q == C_TRACK);

   // ==========================================================
   // Step pulse driver
   dbt_stepper #(
      .SETUP_CYC (SETUP_CYC),
      .HALF_CYC  (HALF_CYC)
   ) u_stepper (
      .clk_i            (clk_i),
      .nrst_i           (nrst_i),
      .st               (stp.drv),
      .wiper_select_n_o (wiper_select_n_o),
      .dir_step_o       (dir_step_o)
   );

   assign stp.run = run_q;
   assign stp.up  = up_q;

   // ==========================================================
   // Limit detection while searching
   always_comb
   begin
      oob_set = 1'b0;
      if (start && !ev_rise[EV_CAL] && !cal_en_i && cmp_above_i
          && pos_q == POS_MIN)
         oob_set = 1'b1;
      else if (stepping && stp.step && !cmp_edge)
      begin
         if (!up_q && pos_q == POS_MIN)
            oob_set = 1'b1;
         if (up_q && inc_run_q >= INC_LIMIT)
            oob_set = 1'b1;
      end
   end

   // ==========================================================
   // Balance controller
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         cst_q   <= C_IDLE;
         run_q   <= 1'b0;
         up_q    <= 1'b0;
         burst_q <= '0;
      end
      else
      begin
         unique case (cst_q)
            C_IDLE:
               if (cal_start)
               begin
                  cst_q   <= C_CAL_UP;
                  run_q   <= 1'b1;
                  up_q    <= 1'b1;
                  burst_q <= '0;
               end
               else if (start && !oob_set)
               begin
                  // Input under threshold needs more resistance
                  cst_q <= C_TRACK;
                  run_q <= 1'b1;
                  up_q  <= ~cmp_above_i;
               end
            C_CAL_UP:
               // One-shot burst; comparator edges are ignored here
               if (stp.step)
               begin
                  burst_q <= burst_q + 1'b1;
                  if (burst_q == CAL_STEPS - 1'b1)
                  begin
                     run_q <= 1'b0;
                     cst_q <= C_CAL_WAIT;
                  end
               end
            C_CAL_WAIT:
               if (!stp.busy)
               begin
                  cst_q <= C_CAL_DN;
                  run_q <= 1'b1;
                  up_q  <= 1'b0;
               end
            C_CAL_DN,
            C_TRACK:
               if (cmp_edge || oob_set)
               begin
                  run_q <= 1'b0;
                  cst_q <= C_DRAIN;
               end
            C_DRAIN:
               if (!stp.busy)
                  cst_q <= C_IDLE;
            default:
            begin
               cst_q <= C_IDLE;
               run_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Running position count; a step that would pass an end clamps
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         pos_q <= POS_MIN;
      else if (cal_start)
         pos_q <= POS_MAX;
      else if (stp.step)
         pos_q <= sat_step(pos_q, up_q);
   end

   // ==========================================================
   // Unbroken increment run, cleared by a comparator edge
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         inc_run_q <= '0;
      else if (start || cmp_edge || (stp.step && !up_q))
         inc_run_q <= '0;
      else if (stp.step && stepping && inc_run_q != INC_LIMIT + 1'b1)
         inc_run_q <= inc_run_q + 1'b1;
   end

   // ==========================================================
   // Out-of-bounds flag holds until the next accepted request
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         limit_reached_flag_o <= 1'b0;
      else if (oob_set)
         limit_reached_flag_o <= 1'b1;
      else if (start)
         limit_reached_flag_o <= 1'b0;
   end

   // ==========================================================
   // Serial read port: answers its address, returns the position
   dbt_ist_t   ist_q;
   logic       scl_q;
   logic       sda_q;
   logic [7:0] sh_q;
   logic [3:0] bit_q;
   logic       rw_q;
   logic       nack_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       i2c_start;
   logic       i2c_stop;

   assign scl_rise  = scl_i && !scl_q;
   assign scl_fall  = !scl_i && scl_q;
   assign i2c_start = scl_i && scl_q && sda_q && !sda_i;
   assign i2c_stop  = scl_i && scl_q && !sda_q && sda_i;
   assign sda_o     = 1'b0;                 // Open drain, pull low only

   // Line history for start, stop and clock edges
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   // Byte engine; writes are acknowledged and discarded
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         ist_q    <= I_IDLE;
         sh_q     <= '0;
         bit_q    <= '0;
         rw_q     <= 1'b0;
         nack_q   <= 1'b0;
         sda_oe_o <= 1'b0;
      end
      else if (i2c_start)
      begin
         ist_q    <= I_ADDR;
         bit_q    <= '0;
         sda_oe_o <= 1'b0;
      end
      else if (i2c_stop)
      begin
         ist_q    <= I_IDLE;
         sda_oe_o <= 1'b0;
      end
      else
      begin
         unique case (ist_q)
            I_IDLE: sda_oe_o <= 1'b0;
            I_ADDR:
               if (scl_rise)
               begin
                  sh_q  <= {sh_q[6:0], sda_i};
                  bit_q <= bit_q + 1'b1;
               end
               else if (scl_fall && bit_q == I2C_BITS)
               begin
                  if (sh_q[7:1] == I2C_ADDR)
                  begin
                     rw_q     <= sh_q[0];
                     sda_oe_o <= 1'b1;
                     ist_q    <= I_AACK;
                  end
                  else
                     ist_q <= I_IDLE;
               end
            I_AACK,
            I_RACK:
            begin
               if (scl_rise)
                  nack_q <= (ist_q == I_RACK) && sda_i;
               if (scl_fall)
               begin
                  bit_q <= '0;
                  if (ist_q == I_RACK && nack_q)
                  begin
                     sda_oe_o <= 1'b0;
                     ist_q    <= I_IDLE;
                  end
                  else if (rw_q)
                  begin
                     // Snapshot so the byte cannot tear mid-transfer
                     sh_q     <= {POS_PAD, pos_q};
                     // First bit out is the top pad bit, not the count
                     sda_oe_o <= ~POS_PAD[$bits(POS_PAD)-1];
                     ist_q    <= I_TX;
                  end
                  else
                  begin
                     sda_oe_o <= 1'b0;
                     ist_q    <= I_RX;
                  end
               end
            end
            I_TX:
               if (scl_fall)
               begin
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == I2C_BITS - 1'b1)
                  begin
                     sda_oe_o <= 1'b0;
                     ist_q    <= I_RACK;
                  end
                  else
                  begin
                     sh_q     <= {sh_q[6:0], 1'b0};
                     sda_oe_o <= ~sh_q[6];
                  end
               end
            I_RX:
               if (scl_rise)
                  bit_q <= bit_q + 1'b1;
               else if (scl_fall && bit_q == I2C_BITS)
               begin
                  sda_oe_o <= 1'b1;
                  ist_q    <= I_WACK;
               end
            I_WACK:
               if (scl_fall)
               begin
                  sda_oe_o <= 1'b0;
                  bit_q    <= '0;
                  ist_q    <= I_RX;
               end
            default: ist_q <= I_IDLE;
         endcase
      end
   end
endmodule

// ### dbt_tracker_chk.sv
// Pin-level assertion checker for the divider balance tracker
`timescale 1ns/1ps
module dbt_tracker_chk #(
   parameter int         SETUP_CYC = 4,
   parameter int         HALF_CYC  = 2,
   parameter logic [6:0] I2C_ADDR  = 7'h2a
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic cal_en_i,
   input wire logic track_en_i,
   input wire logic cmp_above_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic wiper_select_n_o,
   input wire logic dir_step_o,
   input wire logic limit_reached_flag_o
);
   // ====================
   // Burst bookkeeping
   logic [3:0] hi_q;
   logic       up_q;
   logic       cal_q;
   logic [6:0] rise_q;
   logic       idle;

   // Select high for a while means no setup phase is pending
   always_ff @(posedge clk_i)
      if (!nrst_i || !wiper_select_n_o) hi_q <= 4'h0;
      else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
   assign idle = hi_q >= 4'ha;

   // Direction of the running burst, as the pot latches it
   always_ff @(posedge clk_i)
      if (!nrst_i) up_q <= 1'b1;
      else if ($fell(wiper_select_n_o)) up_q <= dir_step_o;

   // First burst of a calibration; only that one must be full length
   always_ff @(posedge clk_i)
      if (!nrst_i) cal_q <= 1'b0;
      else if ($rose(cal_en_i) && idle) cal_q <= 1'b1;
      else if ($rose(wiper_select_n_o)) cal_q <= 1'b0;

   // Rising step edges issued in the current burst
   always_ff @(posedge clk_i)
      if (!nrst_i || $fell(wiper_select_n_o)) rise_q <= 7'h00;
      else if ($rose(dir_step_o) && !wiper_select_n_o)
         rise_q <= rise_q + 7'h01;

   // ====================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   a_reset_quiet_pins: assert property (
      $rose(nrst_i) |-> wiper_select_n_o && !dir_step_o
         && !limit_reached_flag_o && !sda_oe_o)
      else $error("pins not quiet after reset");
   // A rise while deselected is only a direction setup before a burst
   a_step_when_selected: assert property (
      $rose(dir_step_o) |-> (!wiper_select_n_o
         or wiper_select_n_o [*4]))
      else $error("step edge while deselected");
   a_step_high_half: assert property (
      $rose(dir_step_o) |=> dir_step_o)
      else $error("step high half too short");
   a_dir_steady_fall: assert property (
      $fell(wiper_select_n_o) |-> dir_step_o == $past(dir_step_o)
         && dir_step_o == $past(dir_step_o, 3))
      else $error("direction moved around select fall");
   a_cal_select_answer: assert property (
      $rose(cal_en_i) && idle |-> wiper_select_n_o [*4]
         ##[1:4] !wiper_select_n_o)
      else $error("select fall not at setup end");
   a_cal_clears_flag: assert property (
      $rose(cal_en_i) && idle |=> !limit_reached_flag_o)
      else $error("flag kept over calibration start");
   a_flag_sticky_hold: assert property (
      limit_reached_flag_o && !$rose(cal_en_i) && !$rose(track_en_i)
         |=> limit_reached_flag_o)
      else $error("flag dropped without request");
   a_cmp_stops_down: assert property (
      $changed(cmp_above_i) && !wiper_select_n_o && !up_q
         |-> ##[0:6] wiper_select_n_o)
      else $error("stepping went on after comparator edge");
   a_cal_full_burst: assert property (
      $rose(wiper_select_n_o) && cal_q |-> rise_q == 7'h3f)
      else $error("calibration burst not 63 steps");
endmodule

bind dbt_tracker dbt_tracker_chk #(
   .SETUP_CYC(SETUP_CYC),
   .HALF_CYC (HALF_CYC),
   .I2C_ADDR (I2C_ADDR)
) u_chk (
   .clk_i(clk_i), .nrst_i(nrst_i), .cal_en_i(cal_en_i),
   .track_en_i(track_en_i), .cmp_above_i(cmp_above_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .wiper_select_n_o(wiper_select_n_o), .dir_step_o(dir_step_o),
   .limit_reached_flag_o(limit_reached_flag_o)
);

// ### dbt_pot_model.sv
// Behavioural up/down potentiometer with a threshold comparator
`timescale 1ns/1ps
module dbt_pot_model #(
   parameter logic [5:0] WIPER_INIT = 6'h15
) (
   input  wire logic       select_n_i,
   input  wire logic       dir_step_i,
   input  wire logic [6:0] thr_i,
   output logic            cmp_above_o,
   output logic      [5:0] wiper_o,
   output logic            up_o,
   output int              ups_o
);
   // ====================
   // Volatile wiper: power-up position is unknown to the controller
   initial
   begin
      wiper_o = WIPER_INIT;
      up_o    = 1'b1;
      ups_o   = 0;
   end

   // Direction is taken from the step line as select falls
   always @(negedge select_n_i)
      up_o = dir_step_i;

   // One move per rising edge while selected; ends saturate, no wrap
   always @(posedge dir_step_i)
   begin
      if (!select_n_i && up_o)
      begin
         ups_o++;
         if (wiper_o != 6'h3f)
            wiper_o++;
      end
      else if (!select_n_i && wiper_o != 6'h00)
         wiper_o--;
   end

   // Comparator high once the divider sits at or above the threshold
   assign cmp_above_o = {1'b0, wiper_o} >= thr_i;
endmodule

// ### dbt_tracker_bench.sv
// Self-checking bench for the divider balance tracker
`timescale 1ns/1ps
module dbt_tracker_bench
   import dbt_pkg::*;
();
   // ====================
   // Pins and bookkeeping
   logic       clk_i = 1'b0;
   logic       nrst_i = 1'b0;
   logic       cal_en = 1'b0;
   logic       trk_en = 1'b0;
   logic       scl = 1'b1;
   logic       sda_m = 1'b1;
   logic [6:0] thr = 7'h08;
   logic       sda_oe, sda_out, sel_n, dir_step, flag, cmp, pot_up;
   logic [5:0] wiper;
   wire  logic sda_w;
   int         ups;
   int         failures = 0;
   int         num_checks = 0;

   // Open-drain data line with pull-up; when enabled the line is the AND of both levels
   assign sda_w = sda_oe ? (sda_m & sda_out) : sda_m;
   always #20 clk_i = ~clk_i;

   dbt_tracker #(.SETUP_CYC(4), .HALF_CYC(2)) uut (
      .clk_i(clk_i), .nrst_i(nrst_i), .cal_en_i(cal_en),
      .track_en_i(trk_en), .cmp_above_i(cmp), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_out), .sda_oe_o(sda_oe),
      .wiper_select_n_o(sel_n), .dir_step_o(dir_step),
      .limit_reached_flag_o(flag));
   dbt_pot_model pot (
      .select_n_i(sel_n), .dir_step_i(dir_step), .thr_i(thr),
      .cmp_above_o(cmp), .wiper_o(wiper), .up_o(pot_up), .ups_o(ups));

   // ====================
   // Common tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One SCL period; levels held well past the 3-cycle minimum
   task automatic clk_bit(input logic b, output logic s);
      tick(2);
      sda_m = b;
      tick(3);
      scl = 1'b1;
      tick(2);
      s = sda_w;
      tick(2);
      scl = 1'b0;
   endtask

   // Single byte read; the master NACK lets the slave release SDA
   task automatic i2c_read(input logic [6:0] a, output logic [7:0] d,
                           output logic nak);
      logic s;
      int   i;
      sda_m = 1'b0;
      tick(4);
      scl = 1'b0;
      for (i = 6; i >= 0; i--)
         clk_bit(a[i], s);
      clk_bit(1'b1, s);
      clk_bit(1'b1, nak);
      for (i = 7; i >= 0; i--)
         clk_bit(1'b1, d[i]);
      clk_bit(1'b1, s);
      tick(2);
      sda_m = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(4);
      sda_m = 1'b1;
      tick(4);
   endtask

   task automatic rd_expect(input logic [5:0] exp);
      logic [7:0] d;
      logic       nak;
      i2c_read(I2C_ADDR_DEF, d, nak);
      check("address ack", {7'h00, nak}, 8'h00);
      check("count", d, {2'h0, exp});
      check("wiper", {2'h0, wiper}, {2'h0, exp});
   endtask

   // Pulse the requests, then wait, bounded, for a settled idle select
   task automatic run(input logic c, input logic t);
      int hi;
      int n;
      hi = 0;
      cal_en = c;
      trk_en = t;
      tick(2);
      cal_en = 1'b0;
      trk_en = 1'b0;
      for (n = 0; n < 4000 && hi < 12; n++)
      begin
         tick(1);
         hi = sel_n ? hi + 1 : 0;
      end
      check("idle select", {7'h00, hi >= 12}, 8'h01);
   endtask

   // ====================
   // Scenarios
   task automatic t_calibrate;
      int u0;
      u0 = ups;
      thr = 7'h08;
      run(1'b1, 1'b0);
      check("burst pulses", 8'(ups - u0), 8'h3f);
      check("limit flag", {7'h00, flag}, 8'h00);
      rd_expect(6'h07);
   endtask

   task automatic t_track_up;
      thr = 7'h13;
      run(1'b0, 1'b1);
      check("direction", {7'h00, pot_up}, 8'h01);
      rd_expect(6'h13);
   endtask

   task automatic t_track_down;
      thr = 7'h0a;
      run(1'b0, 1'b1);
      check("direction", {7'h00, pot_up}, 8'h00);
      rd_expect(6'h09);
   endtask

   // Tracking alone would stop at 30 after 21 steps
   task automatic t_priority;
      int u0;
      u0 = ups;
      thr = 7'h1e;
      run(1'b1, 1'b1);
      check("burst pulses", 8'(ups - u0), 8'h3f);
      rd_expect(6'h1d);
   endtask

   // Comparator never moves: increments run out at the top
   task automatic t_top_limit;
      thr = 7'h40;
      run(1'b0, 1'b1);
      check("limit flag", {7'h00, flag}, 8'h01);
      rd_expect(6'h3f);
   endtask

   task automatic t_bottom_limit;
      logic [7:0] d;
      logic       nak;
      thr = 7'h00;
      cal_en = 1'b1;
      tick(3);
      check("flag at start", {7'h00, flag}, 8'h00);
      run(1'b0, 1'b0);
      check("limit flag", {7'h00, flag}, 8'h01);
      rd_expect(6'h00);
      check("flag kept", {7'h00, flag}, 8'h01);
      i2c_read(I2C_ADDR_DEF ^ 7'h01, d, nak);
      check("foreign address", {7'h00, nak}, 8'h01);
   endtask

   // Reset in mid-burst, then a fresh calibration
   task automatic t_reset_mid;
      cal_en = 1'b1;
      tick(20);
      nrst_i = 1'b0;
      tick(2);
      check("select in reset", {7'h00, sel_n}, 8'h01);
      check("step in reset", {7'h00, dir_step}, 8'h00);
      nrst_i = 1'b1;
      cal_en = 1'b0;
      tick(4);
      t_calibrate();
   endtask

   // ====================
   // Main sequence and watchdog
   initial
   begin
      tick(12);
      nrst_i = 1'b1;
      tick(4);
      t_calibrate();
      t_track_up();
      t_track_down();
      t_priority();
      t_top_limit();
      t_bottom_limit();
      t_reset_mid();
      print_verdict();
   end

   // Whole run needs well under 10000 cycles
   initial
   begin
      repeat (30000) @(posedge clk_i);
      failures++;
      print_verdict();
   end
endmodule
